// file: isb_pkg.sv
// Overview of operation
// [R1] detector bit 0 sets on dynamic-reserve or signal-input overload
// [R2] detector bit 1 sets on low-pass filter overload
// [R3] detector bit 2 sets on output stage overload
// [R4] detector bit 3 sets when reference loop loses lock
// [R5] detector bit 4 sets on each 200 Hz frequency crossing, either way
// [R6] detector bit 5 sets whenever the time constant is changed
// [R7] detector bit 6 sets on trigger; bit 7 unused
// [R8] error bit 1 sets on battery backup failure; bits 0 and 3 unused
// [R9] error bit 2 sets on RAM self-test fault
// [R10] error bit 4 sets on ROM self-test fault
// [R11] error bit 5 sets on aborted GPIB binary transfer
// [R12] error bit 6 sets on signal processor self-test fault
// [R13] error bit 7 sets on internal math error
// [R14] poll bit 2 high when any enabled error bit is set
// [R15] poll bit 3 high when any enabled detector bit is set
// [R16] enable masks take whole byte or single bit i set to j
// [R17] bits stay set until byte read or clear-all; unused read zero
// [R18] a new event in the clear cycle keeps its bit set
package isb_pkg;
   localparam int unsigned BYTE_W        = 8;
   // detector status bit positions
   localparam int unsigned DET_OVL_BIT   = 0;
   localparam int unsigned DET_FILT_BIT  = 1;
   localparam int unsigned DET_OUT_BIT   = 2;
   localparam int unsigned DET_REFERENCE_LOCK_LOST_BIT  = 3;
   localparam int unsigned DET_RANGE_BIT = 4;
   localparam int unsigned DET_TC_BIT    = 5;
   localparam int unsigned DET_TRIG_BIT  = 6;
   // error status bit positions
   localparam int unsigned ERR_BKUP_BIT  = 1;
   localparam int unsigned ERR_RAM_BIT   = 2;
   localparam int unsigned ERR_ROM_BIT   = 4;
   localparam int unsigned ERR_GPIB_BIT  = 5;
   localparam int unsigned ERR_DSP_BIT   = 6;
   localparam int unsigned ERR_MATH_BIT  = 7;
   // implemented bits
   localparam logic [7:0]  DET_USED      = 8'h7f;
   localparam logic [7:0]  ERR_USED      = 8'hf6;
   // serial poll summary positions
   localparam int unsigned POLL_ERR_BIT  = 2;
   localparam int unsigned POLL_DET_BIT  = 3;
   // reset values
   localparam logic [7:0]  STATUS_RST    = 8'h00;
   localparam logic [7:0]  MASK_RST      = 8'h00;
   // mask write selectors
   localparam logic [1:0]  SEL_NONE      = 2'h0;
   localparam logic [1:0]  SEL_DET       = 2'h1;
   localparam logic [1:0]  SEL_ERR       = 2'h2;
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] mask;
      logic [7:0] rdata;
   } isb_byte_t;
endpackage : isb_pkg

// file: isb_status_byte.sv
`timescale 1ns/100ps
// one sticky status byte with its enable mask and summary
module isb_status_byte
   import isb_pkg::*;
#(
   parameter logic [7:0] USED = 8'hff
) (
   input  wire logic       clk,        // system clock
   input  wire logic       rst,        // async reset, high
   input  wire logic [7:0] set_evt,    // one-cycle set events
   input  wire logic       clr,        // clear-all pulse
   input  wire logic       rd,         // byte read pulse
   input  wire logic       mask_wr,    // mask write pulse
   input  wire logic       mask_bit,   // 1: single-bit write
   input  wire logic [2:0] mask_idx,   // bit index for single-bit write
   input  wire logic [7:0] mask_data,  // byte, or bit value in bit 0
   output logic      [7:0] status,     // sticky status
   output logic      [7:0] mask,       // enable mask
   output logic      [7:0] rdata,      // byte latched at read
   output logic            summary     // any enabled bit set
);
   isb_byte_t s_q, s_d;

   // sticky bits: held, cleared by read or clear-all, new events win
   always_comb begin
      s_d = s_q;
      if (rd) begin
         s_d.rdata = s_q.status;
      end
      if (rd || clr) begin
         s_d.status = STATUS_RST;                           // [R17]
      end
      s_d.status = (s_d.status | set_evt) & USED;           // [R18] [R17]
      if (mask_wr) begin
         if (mask_bit) begin
            s_d.mask[mask_idx] = mask_data[0];              // [R16]
         end else begin
            s_d.mask = mask_data;                           // [R16]
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '{status: STATUS_RST, mask: MASK_RST, rdata: STATUS_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign status  = s_q.status;
   assign mask    = s_q.mask;
   assign rdata   = s_q.rdata;
   assign summary = |(s_q.status & s_q.mask);               // [R14] [R15]
endmodule : isb_status_byte

// file: isb_status_top.sv
`timescale 1ns/100ps
// detector and error status bytes with enable masks and poll summaries
module isb_status_top
   import isb_pkg::*;
(
   input  wire logic       SYS_CLK,          // 100 MHz clock
   input  wire logic       SYS_RST,          // async reset, high
   input  wire logic       RESERVE_OVERLOAD, // dynamic reserve overload level
   input  wire logic       INPUT_OVERLOAD,   // signal input overload level
   input  wire logic       FILTER_OVERLOAD,  // low-pass filter overload level
   input  wire logic       OUTPUT_OVERLOAD,  // output stage overload level
   input  wire logic       REFERENCE_LOCK_LOST, // reference unlock level
   input  wire logic       FREQ_ABOVE_200HZ, // detection freq above 200 Hz level
   input  wire logic       TIME_CONSTANT_CHANGED, // time constant change pulse
   input  wire logic       TRIGGER_EVENT,    // trigger pulse
   input  wire logic       BACKUP_FAIL,      // battery backup failed pulse
   input  wire logic       RAM_FAULT,        // ram self-test fault pulse
   input  wire logic       ROM_FAULT,        // rom self-test fault pulse
   input  wire logic       GPIB_ABORT,       // gpib binary transfer abort pulse
   input  wire logic       DSP_FAULT,        // dsp self-test fault pulse
   input  wire logic       MATH_ERROR,       // internal math error pulse
   input  wire logic       CLEAR_ALL,        // clear-all-status pulse
   input  wire logic       DET_READ,         // detector byte read pulse
   input  wire logic       ERR_READ,         // error byte read pulse
   input  wire logic [1:0] MASK_SEL,         // 1 detector, 2 error mask
   input  wire logic       MASK_WR,          // mask write pulse
   input  wire logic       MASK_BIT,         // single-bit write
   input  wire logic [2:0] MASK_IDX,         // bit index
   input  wire logic [7:0] MASK_DATA,        // byte or bit value
   output logic      [7:0] DET_STATUS,       // live detector status
   output logic      [7:0] ERR_STATUS,       // live error status
   output logic      [7:0] DET_READ_DATA,    // detector byte at last read
   output logic      [7:0] ERR_READ_DATA,    // error byte at last read
   output logic      [7:0] DET_MASK,         // detector enable mask
   output logic      [7:0] ERR_MASK,         // error enable mask
   output logic      [7:0] POLL_SUMMARY      // serial poll bits 2 and 3
);
   typedef struct packed {
      logic prev_above; // last level of above-200 Hz flag
      logic primed;     // history valid; first edge after reset is no crossing
   } isb_edge_t;

   isb_edge_t  e_q, e_d;
   logic [7:0] det_evt;
   logic [7:0] err_evt;
   logic       det_sum;
   logic       err_sum;
   logic       ovl_lvl;

   assign ovl_lvl = RESERVE_OVERLOAD | INPUT_OVERLOAD;

   // previous level for crossing detection, armed one edge after reset
   always_comb begin
      e_d = '{prev_above: FREQ_ABOVE_200HZ, primed: 1'b1};
   end

   // edge register
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         e_q <= '0;
      end else begin
         e_q <= e_d;
      end
   end

   // detector events: conditions held high keep setting their bit, except the range bit, which sets only on a change
   always_comb begin
      det_evt                = 8'h00;
      det_evt[DET_OVL_BIT]   = ovl_lvl;                                  // [R1]
      det_evt[DET_FILT_BIT]  = FILTER_OVERLOAD;                          // [R2]
      det_evt[DET_OUT_BIT]   = OUTPUT_OVERLOAD;                          // [R3]
      det_evt[DET_REFERENCE_LOCK_LOST_BIT]  = REFERENCE_LOCK_LOST;                      // [R4]
      det_evt[DET_RANGE_BIT] = e_q.primed & (FREQ_ABOVE_200HZ ^ e_q.prev_above); // [R5]
      det_evt[DET_TC_BIT]    = TIME_CONSTANT_CHANGED;                    // [R6]
      det_evt[DET_TRIG_BIT]  = TRIGGER_EVENT;                            // [R7]
   end

   // error events
   always_comb begin
      err_evt               = 8'h00;
      err_evt[ERR_BKUP_BIT] = BACKUP_FAIL;                               // [R8]
      err_evt[ERR_RAM_BIT]  = RAM_FAULT;                                 // [R9]
      err_evt[ERR_ROM_BIT]  = ROM_FAULT;                                 // [R10]
      err_evt[ERR_GPIB_BIT] = GPIB_ABORT;                                // [R11]
      err_evt[ERR_DSP_BIT]  = DSP_FAULT;                                 // [R12]
      err_evt[ERR_MATH_BIT] = MATH_ERROR;                                // [R13]
   end

   // detector byte
   isb_status_byte #(.USED(DET_USED)) u_det (
      .clk       (SYS_CLK),
      .rst       (SYS_RST),
      .set_evt   (det_evt),
      .clr       (CLEAR_ALL),
      .rd        (DET_READ),
      .mask_wr   (MASK_WR && (MASK_SEL == SEL_DET)),
      .mask_bit  (MASK_BIT),
      .mask_idx  (MASK_IDX),
      .mask_data (MASK_DATA),
      .status    (DET_STATUS),
      .mask      (DET_MASK),
      .rdata     (DET_READ_DATA),
      .summary   (det_sum)
   );

   // error byte
   isb_status_byte #(.USED(ERR_USED)) u_err (
      .clk       (SYS_CLK),
      .rst       (SYS_RST),
      .set_evt   (err_evt),
      .clr       (CLEAR_ALL),
      .rd        (ERR_READ),
      .mask_wr   (MASK_WR && (MASK_SEL == SEL_ERR)),   // [R16]
      .mask_bit  (MASK_BIT),
      .mask_idx  (MASK_IDX),
      .mask_data (MASK_DATA),
      .status    (ERR_STATUS),
      .mask      (ERR_MASK),
      .rdata     (ERR_READ_DATA),
      .summary   (err_sum)
   );

   // serial poll summary bits
   always_comb begin
      POLL_SUMMARY               = 8'h00;
      POLL_SUMMARY[POLL_ERR_BIT] = err_sum;                              // [R14]
      POLL_SUMMARY[POLL_DET_BIT] = det_sum;                              // [R15]
   end
endmodule : isb_status_top

// file: isb_status_properties.sv
`timescale 1ns/100ps
// watches the status bytes, masks and poll summary at the top ports
module isb_status_properties (
   input wire logic       SYS_CLK,         // clock
   input wire logic       SYS_RST,         // reset
   input wire logic       TRIGGER_EVENT,   // trigger
   input wire logic       FREQ_ABOVE_200HZ, // above-200 Hz level
   input wire logic       FILTER_OVERLOAD, // filter overload
   input wire logic       MATH_ERROR,      // math error
   input wire logic       CLEAR_ALL,       // clear all
   input wire logic       DET_READ,        // detector read
   input wire logic [7:0] DET_STATUS,      // detector byte
   input wire logic [7:0] ERR_STATUS,      // error byte
   input wire logic [7:0] DET_READ_DATA,   // detector read data
   input wire logic [7:0] DET_MASK,        // detector mask
   input wire logic [7:0] ERR_MASK,        // error mask
   input wire logic [7:0] POLL_SUMMARY     // poll bits
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // events land in their bit one cycle later
   trig_sets_a: assert property (
      TRIGGER_EVENT |=> DET_STATUS[6]) else $error("trig bit");
   filt_sets_a: assert property (
      FILTER_OVERLOAD |=> DET_STATUS[1]) else $error("filt bit");
   math_sets_a: assert property (
      MATH_ERROR |=> ERR_STATUS[7]) else $error("math bit");
   range_cross_a: assert property (
      $changed(FREQ_ABOVE_200HZ) |=> DET_STATUS[4]) else $error("range bit");
   // sticky bits, clearing, read latch and unused positions
   unused_zero_a: assert property (
      !DET_STATUS[7] && !ERR_STATUS[0] && !ERR_STATUS[3])
      else $error("unused bit set");
   hold_set_a: assert property (
      DET_STATUS[6] && !DET_READ && !CLEAR_ALL |=> DET_STATUS[6])
      else $error("bit lost");
   clear_wipes_a: assert property (
      CLEAR_ALL && !MATH_ERROR |=> !ERR_STATUS[7])
      else $error("clear failed");
   read_latch_a: assert property (
      DET_READ |=> DET_READ_DATA == $past(DET_STATUS))
      else $error("read data wrong");
   // poll summary bits follow the masked bytes
   poll_err_a: assert property (
      POLL_SUMMARY[2] == |(ERR_STATUS & ERR_MASK))
      else $error("poll err bit");
   poll_det_a: assert property (
      POLL_SUMMARY[3] == |(DET_STATUS & DET_MASK))
      else $error("poll det bit");
endmodule : isb_status_properties

bind isb_status_top isb_status_properties u_props (.SYS_CLK, .SYS_RST, .TRIGGER_EVENT,
   .FREQ_ABOVE_200HZ, .FILTER_OVERLOAD, .MATH_ERROR, .CLEAR_ALL, .DET_READ, .DET_STATUS,
   .ERR_STATUS, .DET_READ_DATA, .DET_MASK, .ERR_MASK, .POLL_SUMMARY);

// file: isb_status_top_tb.sv
`timescale 1ns/100ps
module isb_status_top_tb;
   logic        SYS_CLK, SYS_RST, CLEAR_ALL, DET_READ, ERR_READ, MASK_WR, MASK_BIT;
   logic [1:0]  MASK_SEL;
   logic [2:0]  MASK_IDX;
   logic [7:0]  MASK_DATA, DET_STATUS, ERR_STATUS, DET_READ_DATA, ERR_READ_DATA;
   logic [7:0]  DET_MASK, ERR_MASK, POLL_SUMMARY;
   logic [15:0] ev;
   int          mismatches = 0;
   int          check_count = 0;
   // event inputs taken from one vector
   wire RESERVE_OVERLOAD = ev[0], INPUT_OVERLOAD = ev[1], FILTER_OVERLOAD = ev[2];
   wire OUTPUT_OVERLOAD = ev[3], REFERENCE_LOCK_LOST = ev[4], FREQ_ABOVE_200HZ = ev[5];
   wire TIME_CONSTANT_CHANGED = ev[6], TRIGGER_EVENT = ev[7], BACKUP_FAIL = ev[8];
   wire RAM_FAULT = ev[9], ROM_FAULT = ev[10], GPIB_ABORT = ev[11], DSP_FAULT = ev[12];
   wire MATH_ERROR = ev[13];
   // rows: event vector, expected detector byte, expected error byte
   logic [31:0] rows [14] = '{32'h0001_0100, 32'h0002_0100, 32'h0004_0200, 32'h0008_0400,
      32'h0010_0800, 32'h0020_1000, 32'h0040_2000, 32'h0080_4000, 32'h0100_0002,
      32'h0200_0004, 32'h0400_0010, 32'h0800_0020, 32'h1000_0040, 32'h2000_0080};

   isb_status_top DUT (
      .SYS_CLK               (SYS_CLK),
      .SYS_RST               (SYS_RST),
      .RESERVE_OVERLOAD      (RESERVE_OVERLOAD),
      .INPUT_OVERLOAD        (INPUT_OVERLOAD),
      .FILTER_OVERLOAD       (FILTER_OVERLOAD),
      .OUTPUT_OVERLOAD       (OUTPUT_OVERLOAD),
      .REFERENCE_LOCK_LOST   (REFERENCE_LOCK_LOST),
      .FREQ_ABOVE_200HZ      (FREQ_ABOVE_200HZ),
      .TIME_CONSTANT_CHANGED (TIME_CONSTANT_CHANGED),
      .TRIGGER_EVENT         (TRIGGER_EVENT),
      .BACKUP_FAIL           (BACKUP_FAIL),
      .RAM_FAULT             (RAM_FAULT),
      .ROM_FAULT             (ROM_FAULT),
      .GPIB_ABORT            (GPIB_ABORT),
      .DSP_FAULT             (DSP_FAULT),
      .MATH_ERROR            (MATH_ERROR),
      .CLEAR_ALL             (CLEAR_ALL),
      .DET_READ              (DET_READ),
      .ERR_READ              (ERR_READ),
      .MASK_SEL              (MASK_SEL),
      .MASK_WR               (MASK_WR),
      .MASK_BIT              (MASK_BIT),
      .MASK_IDX              (MASK_IDX),
      .MASK_DATA             (MASK_DATA),
      .DET_STATUS            (DET_STATUS),
      .ERR_STATUS            (ERR_STATUS),
      .DET_READ_DATA         (DET_READ_DATA),
      .ERR_READ_DATA         (ERR_READ_DATA),
      .DET_MASK              (DET_MASK),
      .ERR_MASK              (ERR_MASK),
      .POLL_SUMMARY          (POLL_SUMMARY)
   );

   // free-running clock
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one cycle of events, clear and reads, then one idle cycle
   task automatic cyc(input logic [15:0] e, input logic c, input logic dr, input logic er);
      {ev, CLEAR_ALL, DET_READ, ERR_READ} = {e, c, dr, er};
      @(negedge SYS_CLK);
      {ev, CLEAR_ALL, DET_READ, ERR_READ} = '0;
      @(negedge SYS_CLK);
   endtask : cyc

   // one mask write pulse
   task automatic mwr(input logic [1:0] s, input logic b, input logic [2:0] i,
                      input logic [7:0] d);
      {MASK_SEL, MASK_BIT, MASK_IDX, MASK_DATA, MASK_WR} = {s, b, i, d, 1'b1};
      @(negedge SYS_CLK);
      MASK_WR = 1'b0;
      @(negedge SYS_CLK);
   endtask : mwr

   task end_sim;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // hang guard
   initial begin
      repeat (1000) @(posedge SYS_CLK);
      mismatches++;
      end_sim;
   end

   // main sequence
   initial begin
      {ev, CLEAR_ALL, DET_READ, ERR_READ, MASK_SEL, MASK_BIT, MASK_IDX, MASK_DATA} = '0;
      MASK_WR = 1'b0;
      SYS_RST = 1'b1;
      repeat (8) @(negedge SYS_CLK);
      SYS_RST = 1'b0;
      @(negedge SYS_CLK);
      chk(DET_STATUS | ERR_STATUS, 8'h00);
      chk(DET_MASK | ERR_MASK, 8'h00);
      mwr(2'h1, 1'b0, 3'h0, 8'hff);
      mwr(2'h2, 1'b0, 3'h0, 8'hff);
      // each event alone for one cycle, then one extra idle cycle, then read back
      foreach (rows[i]) begin
         cyc(rows[i][31:16], 1'b0, 1'b0, 1'b0);
         chk(DET_STATUS, rows[i][15:8]);
         chk(ERR_STATUS, rows[i][7:0]);
         chk(POLL_SUMMARY, {4'h0, |rows[i][15:8], |rows[i][7:0], 2'h0});
         @(negedge SYS_CLK);
         cyc(16'h0, 1'b0, 1'b1, 1'b1);
         chk(DET_READ_DATA, rows[i][15:8]);
         chk(ERR_READ_DATA, rows[i][7:0]);
         chk(DET_STATUS | ERR_STATUS, 8'h00);
      end
      // single-bit mask write, then a write with an unused selector
      mwr(2'h2, 1'b1, 3'h5, 8'h00);
      mwr(2'h3, 1'b0, 3'h0, 8'h00);
      chk(ERR_MASK, 8'hdf);
      chk(DET_MASK, 8'hff);
      cyc(16'h0800, 1'b0, 1'b0, 1'b0);
      chk(POLL_SUMMARY, 8'h00);
      mwr(2'h2, 1'b1, 3'h5, 8'h01);
      chk(POLL_SUMMARY, 8'h04);
      // new events beside a clear and a read in the same cycle
      cyc(16'h2080, 1'b1, 1'b0, 1'b1);
      chk(DET_STATUS, 8'h40);
      chk(ERR_STATUS, 8'h80);
      chk(ERR_READ_DATA, 8'h20);
      cyc(16'h0, 1'b1, 1'b0, 1'b0);
      chk(DET_STATUS | ERR_STATUS, 8'h00);
      // mid-run reset: bytes and masks wiped, a level held through it is no crossing
      cyc(16'h0040, 1'b0, 1'b0, 1'b0);
      chk(DET_STATUS, 8'h20);
      {SYS_RST, ev} = {1'b1, 16'h0020};
      repeat (2) @(negedge SYS_CLK);
      SYS_RST = 1'b0;
      repeat (2) @(negedge SYS_CLK);
      chk(DET_STATUS | ERR_STATUS, 8'h00);
      chk(DET_MASK | ERR_MASK, 8'h00);
      chk(POLL_SUMMARY, 8'h00);
      // falling crossing alone sets the range bit
      ev = 16'h0000;
      @(negedge SYS_CLK);
      chk(DET_STATUS, 8'h10);
      end_sim;
   end
endmodule : isb_status_top_tb
